// file: inc/alu_exec_pkg.sv
// shared constants for the logic and arithmetic execution block
package alu_exec_pkg;
	// bus geometry and register byte addresses
	localparam int unsigned ADR_W = 11;
	localparam logic [10:0] ADR_OPCODE = 11'h000;
	localparam logic [10:0] ADR_ACC    = 11'h004;
	localparam logic [10:0] ADR_STATUS = 11'h008;
	localparam logic [10:0] ADR_FUSE   = 11'h00C;
	localparam logic [10:0] ADR_EXEC   = 11'h010;
	localparam logic [10:0] ADR_WDOG   = 11'h014;
	localparam int unsigned FILE_SEL_BIT = 10;
	// status bit positions
	localparam int unsigned ST_C  = 0;
	localparam int unsigned ST_DC = 1;
	localparam int unsigned ST_Z  = 2;
	localparam int unsigned ST_PD = 3;
	localparam int unsigned ST_TO = 4;
	localparam logic [7:0] STATUS_RST = 8'h18;
	// fuse word bits: full-rate select and carry-in select
	localparam int unsigned FUSE_TURBO = 0;
	localparam int unsigned FUSE_CF    = 1;
	localparam logic [1:0]  FUSE_RST   = 2'h3;
	// watchdog config bits: bank of file address, prescaler assignment
	localparam int unsigned WCFG_PSA  = 3;
	localparam logic [3:0]  WCFG_RST  = 4'h0;
	// instruction class carried in opcode register bits 13:12
	localparam int unsigned EXT_LSB    = 12;
	localparam logic [1:0]  EXT_NATIVE = 2'h0;
	localparam logic [1:0]  EXT_BRANCH = 2'h1;
	localparam logic [1:0]  EXT_PMREAD = 2'h2;
	// instruction cycle counts and clock divisors
	localparam logic [2:0] CYC_ORDINARY = 3'h1;
	localparam logic [2:0] CYC_SKIP     = 3'h2;
	localparam logic [2:0] CYC_BRANCH   = 3'h3;
	localparam logic [2:0] CYC_PMREAD   = 3'h4;
	localparam logic [1:0] DIV_SLOW_LAST = 2'h3;
	// opcode bits 11:5 of file register forms
	localparam logic [6:0] OP_OR_W   = 7'h08;
	localparam logic [6:0] OP_OR_F   = 7'h09;
	localparam logic [6:0] OP_AND_W  = 7'h0A;
	localparam logic [6:0] OP_AND_F  = 7'h0B;
	localparam logic [6:0] OP_XOR_W  = 7'h0C;
	localparam logic [6:0] OP_XOR_F  = 7'h0D;
	localparam logic [6:0] OP_ADD_W  = 7'h0E;
	localparam logic [6:0] OP_ADD_F  = 7'h0F;
	localparam logic [6:0] OP_SUB_F  = 7'h05;
	localparam logic [6:0] OP_DEC_F  = 7'h07;
	localparam logic [6:0] OP_NOT_F  = 7'h13;
	localparam logic [6:0] OP_INC_F  = 7'h15;
	localparam logic [6:0] OP_DECSKZ = 7'h17;
	localparam logic [6:0] OP_RR_F   = 7'h19;
	localparam logic [6:0] OP_RL_F   = 7'h1B;
	localparam logic [6:0] OP_SWAP_F = 7'h1D;
	localparam logic [6:0] OP_INCSKZ = 7'h1F;
	// literal forms, opcode bits 11:8
	localparam logic [3:0]  OP_OR_LIT  = 4'hD;
	localparam logic [3:0]  OP_AND_LIT = 4'hE;
	localparam logic [3:0]  OP_XOR_LIT = 4'hF;
	localparam logic [11:0] OP_CLR_WDOG = 12'h004;
	// execution sequencer states
	typedef enum logic {EXEC_IDLE, EXEC_RUN} exec_state_e;
endpackage : alu_exec_pkg

// file: verilog/instr_clk_div.sv
// instruction clock enable: oscillator divided by one or by four
`timescale 1ns/10ps
`default_nettype none
module instr_clk_div (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic restart_i,
	input  wire logic slow_i,
	// enable out
	output logic      ce_o
);
	logic [1:0] phase_q;

	// phase restarts with each instruction so its length is exact
	always_ff @(posedge clk_i)
	begin
		if (rst_i || restart_i || ce_o)
			phase_q <= 2'h0;
		else
			phase_q <= phase_q + 2'h1;
	end

	assign ce_o = !slow_i || (phase_q == alu_exec_pkg::DIV_SLOW_LAST);
endmodule : instr_clk_div
`default_nettype wire

// file: verilog/alu_core.sv
// opcode decode and combinational datapath for one instruction
`timescale 1ns/10ps
`default_nettype none
module alu_core (
	// operands
	input  wire logic [11:0] op_i,
	input  wire logic [7:0]  w_i,
	input  wire logic [7:0]  f_i,
	input  wire logic        c_i,
	input  wire logic        cf_i,
	// result
	output logic [7:0]       res_o,
	output logic             to_f_o,
	output logic             wr_o,
	// flag updates
	output logic             upd_z_o,
	output logic             upd_c_o,
	output logic             upd_dc_o,
	output logic             c_o,
	output logic             dc_o,
	output logic             z_o,
	// side effects
	output logic             skip_o,
	output logic             wdog_clr_o
);
	logic       add_cin;
	logic       sub_cin;
	logic [8:0] sum9;
	logic [4:0] sum_lo;
	logic [8:0] dif9;
	logic [4:0] dif_lo;

	// carry joins only while the carry-in select fuse is 0
	assign add_cin = cf_i ? 1'b0 : c_i;
	assign sub_cin = cf_i ? 1'b1 : c_i;
	assign sum9    = {1'b0, w_i} + {1'b0, f_i} + {8'h00, add_cin};
	assign sum_lo  = {1'b0, w_i[3:0]} + {1'b0, f_i[3:0]} + {4'h0, add_cin};
	// f - w - !c is f + ~w + c: carry out means no borrow
	assign dif9    = {1'b0, f_i} + {1'b0, ~w_i} + {8'h00, sub_cin};
	assign dif_lo  = {1'b0, f_i[3:0]} + {1'b0, ~w_i[3:0]} + {4'h0, sub_cin};

	// decode; unlisted opcodes do nothing
	always_comb
	begin
		res_o      = f_i;
		to_f_o     = 1'b1;
		wr_o       = 1'b1;
		upd_z_o    = 1'b1;
		upd_c_o    = 1'b0;
		upd_dc_o   = 1'b0;
		c_o        = c_i;
		dc_o       = 1'b0;
		skip_o     = 1'b0;
		wdog_clr_o = 1'b0;
		if (op_i == alu_exec_pkg::OP_CLR_WDOG)
		begin
			wr_o       = 1'b0;
			upd_z_o    = 1'b0;
			wdog_clr_o = 1'b1;
		end
		else if (op_i[11:8] == alu_exec_pkg::OP_AND_LIT)
		begin
			res_o  = w_i & op_i[7:0];
			to_f_o = 1'b0;
		end
		else if (op_i[11:8] == alu_exec_pkg::OP_OR_LIT)
		begin
			res_o  = w_i | op_i[7:0];
			to_f_o = 1'b0;
		end
		else if (op_i[11:8] == alu_exec_pkg::OP_XOR_LIT)
		begin
			res_o  = w_i ^ op_i[7:0];
			to_f_o = 1'b0;
		end
		else
		begin
			case (op_i[11:5])
				alu_exec_pkg::OP_AND_F:  res_o = f_i & w_i;
				alu_exec_pkg::OP_AND_W:
				begin
					res_o  = f_i & w_i;
					to_f_o = 1'b0;
				end
				alu_exec_pkg::OP_OR_F:   res_o = f_i | w_i;
				alu_exec_pkg::OP_OR_W:
				begin
					res_o  = f_i | w_i;
					to_f_o = 1'b0;
				end
				alu_exec_pkg::OP_XOR_F:  res_o = f_i ^ w_i;
				alu_exec_pkg::OP_XOR_W:
				begin
					res_o  = f_i ^ w_i;
					to_f_o = 1'b0;
				end
				alu_exec_pkg::OP_NOT_F:  res_o = f_i ^ 8'hFF;
				alu_exec_pkg::OP_ADD_F, alu_exec_pkg::OP_ADD_W:
				begin
					res_o    = sum9[7:0];
					to_f_o   = (op_i[11:5] == alu_exec_pkg::OP_ADD_F);
					upd_c_o  = 1'b1;
					upd_dc_o = 1'b1;
					c_o      = sum9[8];
					dc_o     = sum_lo[4];
				end
				alu_exec_pkg::OP_SUB_F:
				begin
					res_o    = dif9[7:0];
					upd_c_o  = 1'b1;
					upd_dc_o = 1'b1;
					c_o      = dif9[8];
					dc_o     = dif_lo[4];
				end
				alu_exec_pkg::OP_DEC_F:  res_o = f_i - 8'h01;
				alu_exec_pkg::OP_INC_F:  res_o = f_i + 8'h01;
				alu_exec_pkg::OP_DECSKZ:
				begin
					res_o   = f_i - 8'h01;
					upd_z_o = 1'b0;
					skip_o  = (f_i == 8'h01);
				end
				alu_exec_pkg::OP_INCSKZ:
				begin
					res_o   = f_i + 8'h01;
					upd_z_o = 1'b0;
					skip_o  = (f_i == 8'hFF);
				end
				alu_exec_pkg::OP_RL_F:
				begin
					res_o   = {f_i[6:0], c_i};
					c_o     = f_i[7];
					upd_c_o = 1'b1;
					upd_z_o = 1'b0;
				end
				alu_exec_pkg::OP_RR_F:
				begin
					res_o   = {c_i, f_i[7:1]};
					c_o     = f_i[0];
					upd_c_o = 1'b1;
					upd_z_o = 1'b0;
				end
				alu_exec_pkg::OP_SWAP_F:
				begin
					res_o   = {f_i[3:0], f_i[7:4]};
					upd_z_o = 1'b0;
				end
				default:
				begin
					wr_o    = 1'b0;
					upd_z_o = 1'b0;
				end
			endcase
		end
		z_o = (res_o == 8'h00);
	end
endmodule : alu_core
`default_nettype wire

// file: verilog/logic_arith_instr_exec.sv
// execution core for logical, arithmetic, rotate and swap instructions
// Contract
// - full-rate clocking runs ordinary instructions at one per clock cycle.
// - branches take three clocks, program memory read four, at full rate.
// - instruction clock is oscillator over one or four, chosen by fuse word.
// - skip instructions take one or two cycles, slow mode four or eight.
// - AND to register, to accumulator, or literal; only zero flag changes.
// - OR to register, to accumulator, or literal; only zero flag changes.
// - XOR to register, to accumulator, or literal; only zero flag changes.
// - complement inverts file register in place, zero flag only.
// - add accumulator and register into either; carry, digit carry, zero change.
// - add includes old carry while carry-in select fuse is zero.
// - subtract register minus accumulator, borrow by carry when fuse zero.
// - watchdog clear resets counter, prescaler if assigned, sets expired, sleep.
// - decrement register in place, zero flag only.
// - increment register in place, zero flag only.
// - decrement and skip next when zero, flags untouched.
// - increment and skip next when zero, flags untouched.
// - rotate register through carry either way, carry flag only.
// - swap register nibbles in place, no flag changes.
// - status bits: carry 0, digit carry 1, zero 2, sleep 3, expired 4.
// - file register operand addresses a space from 00h to FFh.
`timescale 1ns/10ps
`default_nettype none
module logic_arith_instr_exec #(
	parameter int unsigned FILE_DEPTH = 256
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [10:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// execution state
	output logic             busy_o
);
	localparam int unsigned FA_W = $clog2(FILE_DEPTH);

	alu_exec_pkg::exec_state_e state_q;

	logic [7:0]  file_q [FILE_DEPTH];
	logic [7:0]  w_q;
	logic [7:0]  status_q;
	logic [1:0]  fuse_q;
	logic [3:0]  wcfg_q;
	logic [13:0] opcode_q;
	logic [2:0]  cyc_left_q;
	logic        skip_pend_q;
	logic [7:0]  presc_q;
	logic [7:0]  wdog_q;
	logic [31:0] rdata;
	logic        req;
	logic        wr_req;
	logic        hit_opcode;
	logic        hit_acc;
	logic        hit_status;
	logic        hit_fuse;
	logic        hit_exec;
	logic        hit_wdog;
	logic        hit_file;
	logic        start;
	logic        go;
	logic        go_native;
	logic [1:0]  ext_class;
	logic [FA_W-1:0] f_addr;
	logic [7:0]  f_val;
	logic        ce;
	logic        wdog_tick;
	logic [2:0]  cycles;
	// datapath results
	logic [7:0]  res;
	logic        to_f;
	logic        dp_wr;
	logic        upd_z;
	logic        upd_c;
	logic        upd_dc;
	logic        c_new;
	logic        dc_new;
	logic        z_new;
	logic        skip;
	logic        wdog_clr;

	// a request is taken in its first cycle, answered one edge later
	assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_req = req && wb_we_i;

	// address decode; anything else is acked with zero data
	always_comb
	begin
		hit_opcode = 1'b0;
		hit_acc    = 1'b0;
		hit_status = 1'b0;
		hit_fuse   = 1'b0;
		hit_exec   = 1'b0;
		hit_wdog   = 1'b0;
		hit_file   = 1'b0;
		if (wb_adr_i[alu_exec_pkg::FILE_SEL_BIT])
			hit_file = 1'b1;
		else if (wb_adr_i == alu_exec_pkg::ADR_OPCODE)
			hit_opcode = 1'b1;
		else if (wb_adr_i == alu_exec_pkg::ADR_ACC)
			hit_acc = 1'b1;
		else if (wb_adr_i == alu_exec_pkg::ADR_STATUS)
			hit_status = 1'b1;
		else if (wb_adr_i == alu_exec_pkg::ADR_FUSE)
			hit_fuse = 1'b1;
		else if (wb_adr_i == alu_exec_pkg::ADR_EXEC)
			hit_exec = 1'b1;
		else if (wb_adr_i == alu_exec_pkg::ADR_WDOG)
			hit_wdog = 1'b1;
	end

	// an opcode write starts an instruction only while idle;
	// one written during a run is dropped silently
	assign start = wr_req && hit_opcode && (wb_sel_i[1:0] == 2'h3)
		&& (state_q == alu_exec_pkg::EXEC_IDLE);
	// after a taken skip the next instruction is consumed unexecuted
	assign go        = start && !skip_pend_q;
	assign ext_class = wb_dat_i[alu_exec_pkg::EXT_LSB +: 2];
	assign go_native = go && (ext_class == alu_exec_pkg::EXT_NATIVE);

	// operand address: bank bits on top of the five opcode bits
	assign f_addr = FA_W'({wcfg_q[2:0], wb_dat_i[4:0]});
	assign f_val  = file_q[f_addr];

	alu_core u_alu (
		.op_i       (wb_dat_i[11:0]),
		.w_i        (w_q),
		.f_i        (f_val),
		.c_i        (status_q[alu_exec_pkg::ST_C]),
		.cf_i       (fuse_q[alu_exec_pkg::FUSE_CF]),
		.res_o      (res),
		.to_f_o     (to_f),
		.wr_o       (dp_wr),
		.upd_z_o    (upd_z),
		.upd_c_o    (upd_c),
		.upd_dc_o   (upd_dc),
		.c_o        (c_new),
		.dc_o       (dc_new),
		.z_o        (z_new),
		.skip_o     (skip),
		.wdog_clr_o (wdog_clr)
	);

	instr_clk_div u_div (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.restart_i (go),
		.slow_i    (!fuse_q[alu_exec_pkg::FUSE_TURBO]),
		.ce_o      (ce)
	);

	// instruction cycles by class; each lasts one divided clock
	always_comb
	begin
		if (ext_class == alu_exec_pkg::EXT_BRANCH)
			cycles = alu_exec_pkg::CYC_BRANCH;
		else if (ext_class == alu_exec_pkg::EXT_PMREAD)
			cycles = alu_exec_pkg::CYC_PMREAD;
		else if (skip)
			cycles = alu_exec_pkg::CYC_SKIP;
		else
			cycles = alu_exec_pkg::CYC_ORDINARY;
	end

	// sequencer: busy for cycles times the divisor clocks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q    <= alu_exec_pkg::EXEC_IDLE;
			cyc_left_q <= 3'h0;
		end
		else
		begin
			case (state_q)
				alu_exec_pkg::EXEC_IDLE:
				begin
					if (go)
					begin
						state_q    <= alu_exec_pkg::EXEC_RUN;
						cyc_left_q <= cycles;
					end
				end
				alu_exec_pkg::EXEC_RUN:
				begin
					if (ce)
					begin
						cyc_left_q <= cyc_left_q - 3'h1;
						if (cyc_left_q == 3'h1)
							state_q <= alu_exec_pkg::EXEC_IDLE;
					end
				end
				default: state_q <= alu_exec_pkg::EXEC_IDLE;
			endcase
		end
	end

	// busy output mirrors the sequencer from a flop of its own
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			busy_o <= 1'b0;
		else if (go)
			busy_o <= 1'b1;
		else if (state_q == alu_exec_pkg::EXEC_RUN && ce && cyc_left_q == 3'h1)
			busy_o <= 1'b0;
	end

	// skip marker: set by a taken skip, cleared by the swallowed opcode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			skip_pend_q <= 1'b0;
		else if (go_native && skip)
			skip_pend_q <= 1'b1;
		else if (start)
			skip_pend_q <= 1'b0;
	end

	// last opcode accepted, readable back
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			opcode_q <= 14'h0000;
		else if (go)
			opcode_q <= wb_dat_i[13:0];
	end

	// file registers: bus port and instruction results share one write
	always_ff @(posedge clk_i)
	begin
		if (wr_req && hit_file && wb_sel_i[0])
			file_q[FA_W'(wb_adr_i[9:2])] <= wb_dat_i[7:0];
		else if (go_native && dp_wr && to_f)
			file_q[f_addr] <= res;
	end

	// accumulator
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			w_q <= 8'h00;
		else if (wr_req && hit_acc && wb_sel_i[0])
			w_q <= wb_dat_i[7:0];
		else if (go_native && dp_wr && !to_f)
			w_q <= res;
	end

	// status flags; instruction effects land after any bus write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_q <= alu_exec_pkg::STATUS_RST;
		else
		begin
			if (wr_req && hit_status && wb_sel_i[0])
				status_q <= wb_dat_i[7:0];
			if (go_native && upd_z)
				status_q[alu_exec_pkg::ST_Z] <= z_new;
			if (go_native && upd_c)
				status_q[alu_exec_pkg::ST_C] <= c_new;
			if (go_native && upd_dc)
				status_q[alu_exec_pkg::ST_DC] <= dc_new;
			if (wdog_tick && wdog_q == 8'hFF)
				status_q[alu_exec_pkg::ST_TO] <= 1'b0;
			if (go_native && wdog_clr)
			begin
				status_q[alu_exec_pkg::ST_TO] <= 1'b1;
				status_q[alu_exec_pkg::ST_PD] <= 1'b1;
			end
		end
	end

	// fuse word and watchdog config, software owned
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fuse_q <= alu_exec_pkg::FUSE_RST;
			wcfg_q <= alu_exec_pkg::WCFG_RST;
		end
		else if (wr_req && wb_sel_i[0] && state_q == alu_exec_pkg::EXEC_IDLE)
		begin
			// changing the divisor mid-instruction would skew its length
			if (hit_fuse)
				fuse_q <= wb_dat_i[1:0];
			if (hit_wdog)
				wcfg_q <= wb_dat_i[3:0];
		end
	end

	// watchdog counts instruction clocks, through the prescaler if assigned
	assign wdog_tick = ce && (!wcfg_q[alu_exec_pkg::WCFG_PSA] || presc_q == 8'hFF);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || (go_native && wdog_clr))
		begin
			presc_q <= 8'h00;
			wdog_q  <= 8'h00;
		end
		else
		begin
			if (ce && wcfg_q[alu_exec_pkg::WCFG_PSA])
				presc_q <= presc_q + 8'h01;
			if (wdog_tick)
				wdog_q <= wdog_q + 8'h01;
		end
	end

	// read data mux; narrow registers sit in the low bits
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (hit_file)
			rdata[7:0] = file_q[FA_W'(wb_adr_i[9:2])];
		else if (hit_opcode)
			rdata[13:0] = opcode_q;
		else if (hit_acc)
			rdata[7:0] = w_q;
		else if (hit_status)
			rdata[7:0] = status_q;
		else if (hit_fuse)
			rdata[1:0] = fuse_q;
		else if (hit_exec)
			rdata[4:0] = {skip_pend_q, busy_o, cyc_left_q};
		else if (hit_wdog)
			rdata[15:0] = {wdog_q, 4'h0, wcfg_q};
	end

	// ack one edge after the request, dropped the edge after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req;
			if (req && !wb_we_i)
				wb_dat_o <= rdata;
		end
	end
endmodule : logic_arith_instr_exec
`default_nettype wire

// file: test/logic_arith_instr_exec_assertions.sv
// checker for bus handshake and instruction timing of the execution core
`timescale 1ns/10ps
`default_nettype none
module logic_arith_instr_exec_assertions #(
	parameter int unsigned FILE_DEPTH = 256
) (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// bus and state
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [10:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        busy_o
);
	logic       take;
	logic       idle_wr;
	logic [1:0] fuse_q;
	logic [1:0] cls_q;
	logic [4:0] len_q;
	logic [4:0] base;
	logic [4:0] exp_len;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// fuse, watchdog config and opcode writes only land while the core is idle
	assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idle_wr = take && wb_we_i && !busy_o;
	// expected busy run; slow clocking stretches it four times
	assign base    = (cls_q == alu_exec_pkg::EXT_BRANCH) ? 5'h03 :
		(cls_q == alu_exec_pkg::EXT_PMREAD) ? 5'h04 : 5'h01;
	assign exp_len = fuse_q[alu_exec_pkg::FUSE_TURBO] ? base : {base[2:0], 2'h0};
	// shadow of the fuse word and of the last accepted class
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fuse_q <= alu_exec_pkg::FUSE_RST;
			cls_q  <= alu_exec_pkg::EXT_NATIVE;
		end
		else
		begin
			if (idle_wr && wb_sel_i[0] && wb_adr_i == alu_exec_pkg::ADR_FUSE)
				fuse_q <= wb_dat_i[1:0];
			if (idle_wr && wb_sel_i[1:0] == 2'h3 && wb_adr_i == alu_exec_pkg::ADR_OPCODE)
				cls_q <= wb_dat_i[13:12];
		end
	end
	// length of the current busy run
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !busy_o)
			len_q <= 5'h00;
		else
			len_q <= len_q + 5'h01;
	end
	sequence s_unmapped_rd;
		take && !wb_we_i && wb_adr_i >= 11'h018 && wb_adr_i < 11'h400;
	endsequence
	sequence s_branch_run;
		busy_o [*3] ##1 !busy_o;
	endsequence
	a_ack_follows: assert property (take |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_caused: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	a_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !wb_ack_o && !busy_o && wb_dat_o == 32'h0)
		else $error("outputs active after reset");
	a_unmapped_zero: assert property (s_unmapped_rd |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_busy_cause: assert property ($rose(busy_o) |->
		$past(idle_wr && wb_adr_i == alu_exec_pkg::ADR_OPCODE))
		else $error("busy without opcode write");
	a_busy_len: assert property ($fell(busy_o) |-> len_q == exp_len ||
		(cls_q == alu_exec_pkg::EXT_NATIVE && len_q == {exp_len[3:0], 1'b0}))
		else $error("wrong busy length");
	a_branch_run: assert property ($rose(busy_o) && fuse_q[0] &&
		cls_q == alu_exec_pkg::EXT_BRANCH |-> s_branch_run)
		else $error("branch not three cycles");
endmodule : logic_arith_instr_exec_assertions
bind logic_arith_instr_exec logic_arith_instr_exec_assertions #(
	.FILE_DEPTH(FILE_DEPTH)
) i_checker (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o
);
`default_nettype wire

// file: test/test_logic_arith_instr_exec.sv
// self-checking bench for the logic and arithmetic execution core
`timescale 1ns/10ps
`default_nettype none
module test_logic_arith_instr_exec;
	// file register 10h of bank 0 on the bus
	localparam logic [10:0] FA = 11'h440;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [10:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        busy_o;
	logic [31:0] rd_q;
	logic        bsy0;
	int          ncyc;
	int          fails = 0;
	int          total_checks = 0;
	logic_arith_instr_exec i_dut (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o
	);
	// 50 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// one classic cycle, held up to the edge that samples ack high, released there
	task automatic bus(input logic we, input logic [10:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		// no wait limit here: a missing ack is left to the watchdog
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1);
		check("ack latency", n, 2);
		rd_q = wb_dat_o;
		bsy0 = busy_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 4'h1);
	endtask : wr
	task automatic rd(input logic [10:0] a, input logic [7:0] e, input string w);
		bus(1'b0, a, 32'h0, 4'hF);
		check(w, {24'h0, rd_q[7:0]}, {24'h0, e});
	endtask : rd
	// count the cycles one opcode keeps the core busy
	task automatic exec(input logic [13:0] op);
		bus(1'b1, alu_exec_pkg::ADR_OPCODE, {18'h0, op}, 4'h3);
		ncyc = int'(bsy0);
		@(posedge clk_i);
		while (busy_o === 1'b1 && ncyc < 40)
		begin
			ncyc++;
			@(posedge clk_i);
		end
	endtask : exec
	// load operands, run one opcode, check destination and flags
	task automatic run(input logic [11:0] op, input logic [7:0] a, f, st,
		input logic to_f, input logic [7:0] r, sx);
		wr(alu_exec_pkg::ADR_ACC, a);
		wr(FA, f);
		wr(alu_exec_pkg::ADR_STATUS, st);
		exec({2'h0, op});
		rd(to_f ? FA : alu_exec_pkg::ADR_ACC, r, "result");
		rd(alu_exec_pkg::ADR_STATUS, sx, "status");
	endtask : run
	task automatic t_reset();
		rd(alu_exec_pkg::ADR_STATUS, 8'h18, "status");
		rd(alu_exec_pkg::ADR_FUSE, 8'h03, "fuse");
		rd(alu_exec_pkg::ADR_ACC, 8'h00, "acc");
		rd(alu_exec_pkg::ADR_EXEC, 8'h00, "exec");
		wr(11'h018, 8'h55);
		rd(11'h018, 8'h00, "unmapped");
		$display("reset test done");
	endtask : t_reset
	// every logical form; first three give zero, the rest all ones
	task automatic t_logic();
		logic [11:0] op [9] = '{12'h170, 12'h150, 12'hE3C, 12'h130, 12'h110,
			12'hD3C, 12'h1B0, 12'h190, 12'hF3C};
		logic [7:0] st;
		for (int i = 0; i < 9; i++)
		begin
			st = (i < 3) ? 8'h03 : 8'h07;
			run(op[i], 8'hC3, 8'h3C, st, i % 3 == 0,
				(i < 3) ? 8'h00 : 8'hFF, st ^ 8'h04);
		end
		$display("logic test done");
	endtask : t_logic
	task automatic t_arith();
		run(12'h1F0, 8'h88, 8'h88, 8'h01, 1'b1, 8'h10, 8'h03);
		wr(alu_exec_pkg::ADR_FUSE, 8'h01);
		run(12'h1D0, 8'hFF, 8'h00, 8'h01, 1'b0, 8'h00, 8'h07);
		run(12'h0B0, 8'h04, 8'h05, 8'h00, 1'b1, 8'h00, 8'h07);
		wr(alu_exec_pkg::ADR_FUSE, 8'h03);
		run(12'h0B0, 8'h01, 8'h10, 8'h00, 1'b1, 8'h0F, 8'h01);
		$display("arithmetic test done");
	endtask : t_arith
	task automatic t_unary();
		run(12'h2B0, 8'h00, 8'hFF, 8'h03, 1'b1, 8'h00, 8'h07);
		run(12'h0F0, 8'h00, 8'h01, 8'h03, 1'b1, 8'h00, 8'h07);
		run(12'h270, 8'h00, 8'hF0, 8'h07, 1'b1, 8'h0F, 8'h03);
		run(12'h370, 8'h00, 8'h81, 8'h01, 1'b1, 8'h03, 8'h01);
		run(12'h330, 8'h00, 8'h01, 8'h00, 1'b1, 8'h00, 8'h01);
		run(12'h3B0, 8'h00, 8'hA5, 8'h07, 1'b1, 8'h5A, 8'h07);
		wr(alu_exec_pkg::ADR_STATUS, 8'h00);
		exec(14'h0004);
		// counter restarts at the clear and ticks every clock until the read is taken
		bus(1'b0, alu_exec_pkg::ADR_WDOG, 32'h0, 4'hF);
		check("watchdog", rd_q, 32'h0000_0300);
		rd(alu_exec_pkg::ADR_STATUS, 8'h18, "status");
		// bank 1 puts opcode operand 10h at file location 30h
		wr(alu_exec_pkg::ADR_WDOG, 8'h01);
		wr(11'h4C0, 8'h41);
		exec(14'h02B0);
		rd(11'h4C0, 8'h42, "bank");
		wr(alu_exec_pkg::ADR_WDOG, 8'h00);
		$display("unary test done");
	endtask : t_unary
	// skips swallow the next opcode; counts in both clock rates
	task automatic t_skip();
		run(12'h2F0, 8'h00, 8'h02, 8'h00, 1'b1, 8'h01, 8'h00);
		check("cycles", ncyc, 1);
		run(12'h2F0, 8'h00, 8'h01, 8'h07, 1'b1, 8'h00, 8'h07);
		check("cycles", ncyc, 2);
		exec(14'h02B0);
		check("skipped", ncyc, 0);
		rd(FA, 8'h00, "skipped");
		wr(alu_exec_pkg::ADR_FUSE, 8'h00);
		run(12'h3F0, 8'h00, 8'hFF, 8'h00, 1'b1, 8'h00, 8'h00);
		check("cycles", ncyc, 8);
		exec(14'h02B0);
		check("skipped", ncyc, 0);
		exec(14'h02B0);
		check("cycles", ncyc, 4);
		exec(14'h1000);
		check("cycles", ncyc, 12);
		wr(alu_exec_pkg::ADR_FUSE, 8'h03);
		exec(14'h1000);
		check("cycles", ncyc, 3);
		exec(14'h2000);
		check("cycles", ncyc, 4);
		$display("skip and timing test done");
	endtask : t_skip
	// an opcode written while a branch still runs is dropped
	task automatic t_refuse();
		bus(1'b1, alu_exec_pkg::ADR_OPCODE, 32'h1000, 4'h3);
		exec(14'h02B0);
		bus(1'b0, alu_exec_pkg::ADR_OPCODE, 32'h0, 4'hF);
		check("opcode", {18'h0, rd_q[13:0]}, 32'h1000);
		$display("refusal test done");
	endtask : t_refuse
	initial
	begin
		rst_i    = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 11'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_logic();
		t_arith();
		t_unary();
		t_skip();
		t_refuse();
		summarize();
	end
	// the run needs under six hundred cycles; stop a hang at five thousand
	initial
	begin
		#100000;
		fails++;
		summarize();
	end
endmodule : test_logic_arith_instr_exec
`default_nettype wire
